// ===== cmr_handshake.sv
// cpu memory request handshake with translation, cache and register block
`timescale 1ns/1ns

// Behaviour
// - The request to storage stays high for the whole of a read or write transfer.
// - The write signal is high for processor-to-memory moves and low for reads.
// - Each 16-bit virtual address is mapped to an 18-bit physical address first.
// - A 1K-word cache is looked up in parallel with the mapping, adding no delay.
// - Local and multiport memory are decoded in one 256K space without overlap.
// - Local memory is selected in 32K modules from the upper physical bits.
// - 128 registers sit on chip and are reached with no memory request.
// - Every request carries one of four access kinds.
module cmr_handshake
#(
    parameter int PAGE_W = cmr_pkg::PAGE_W,
    parameter int CACHE_WORDS = cmr_pkg::CACHE_WORDS
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // cpu side
    input wire cmr_pkg::cmr_cpu_req_t cpu_req,
    output cmr_pkg::cmr_cpu_rsp_t cpu_rsp,
    // page table load
    input wire logic pt_we,
    input wire logic [cmr_pkg::PAGE_W-1:0] pt_page,
    input wire logic [cmr_pkg::FRAME_W-1:0] pt_frame,
    // local memory boundary
    input wire logic [cmr_pkg::PADDR_W-1:0] local_limit,
    // register block
    input wire logic reg_we,
    input wire logic [cmr_pkg::REG_IDX_W-1:0] reg_idx,
    input wire logic [cmr_pkg::DATA_W-1:0] reg_wdata,
    output logic [cmr_pkg::DATA_W-1:0] reg_rdata,
    // storage side
    output cmr_pkg::cmr_mem_req_t mem_req,
    input wire logic mem_data_ready,
    input wire logic [cmr_pkg::DATA_W-1:0] info_bus
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed
    {
        cmr_pkg::cmr_state_t state;
        cmr_pkg::cmr_mem_req_t mem;
        cmr_pkg::cmr_cpu_rsp_t rsp;
        // line index of the access in flight, taken from the virtual address
        logic [cmr_pkg::CACHE_IDX_W-1:0] cidx;
    } cmr_st_t;

    cmr_st_t s_r;
    cmr_st_t s_nxt;

    logic [cmr_pkg::FRAME_W-1:0] page_table [0:(1<<PAGE_W)-1];
    logic [cmr_pkg::DATA_W-1:0] cache_data [0:CACHE_WORDS-1];
    logic [cmr_pkg::PADDR_W-cmr_pkg::CACHE_IDX_W-1:0] cache_tag [0:CACHE_WORDS-1];
    logic cache_vld [0:CACHE_WORDS-1];
    logic [cmr_pkg::DATA_W-1:0] reg_block [0:cmr_pkg::REG_COUNT-1];

    // ****************************************
    // translation and cache lookup
    // ****************************************
    logic [cmr_pkg::PADDR_W-1:0] paddr;
    logic [cmr_pkg::CACHE_IDX_W-1:0] cidx;
    logic [cmr_pkg::PADDR_W-cmr_pkg::CACHE_IDX_W-1:0] ctag;
    logic hit;
    logic is_write;
    logic in_local;

    // mapping and cache index use the same cycle
    // index from the untranslated address so the lookup need not wait for the map;
    // two pages mapped to one frame may hold the same word in two lines
    always_comb
    begin
        paddr = {page_table[cpu_req.vaddr[cmr_pkg::VADDR_W-1 -: PAGE_W]],
                 cpu_req.vaddr[cmr_pkg::VADDR_W-PAGE_W-1:0]};
        cidx = cpu_req.vaddr[cmr_pkg::CACHE_IDX_W-1:0];
        ctag = paddr[cmr_pkg::PADDR_W-1:cmr_pkg::CACHE_IDX_W];
        hit = cache_vld[cidx] && (cache_tag[cidx] == ctag);
        is_write = (cpu_req.kind == cmr_pkg::operand_store_access);
        // at or above the limit is multiport, so the two ranges never overlap
        in_local = (paddr < local_limit);
    end

    // ****************************************
    // handshake sequencer
    // ****************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rsp.done = 1'b0;
        case (s_r.state)
            cmr_pkg::st_idle:
            begin
                if (cpu_req.valid)
                begin
                    if (hit && !is_write)
                    begin
                        s_nxt.rsp.rdata = cache_data[cidx];
                        s_nxt.rsp.cache_hit = 1'b1;
                        s_nxt.rsp.done = 1'b1;
                        // dead cycle so a still-raised valid is not taken twice
                        s_nxt.state = cmr_pkg::st_done;
                    end
                    else
                    begin
                        s_nxt.mem.request = 1'b1;
                        s_nxt.mem.write = is_write;
                        s_nxt.mem.kind = cpu_req.kind;
                        s_nxt.mem.paddr = paddr;
                        s_nxt.mem.local_sel = in_local;
                        s_nxt.mem.multiport_sel = !in_local;
                        s_nxt.mem.module_sel =
                            paddr[cmr_pkg::PADDR_W-1 -: cmr_pkg::MOD_SEL_W];
                        s_nxt.mem.wdata = cpu_req.wdata;
                        s_nxt.cidx = cidx;
                        s_nxt.rsp.busy = 1'b1;
                        s_nxt.rsp.cache_hit = 1'b0;
                        s_nxt.state = cmr_pkg::st_mem;
                    end
                end
            end
            cmr_pkg::st_mem:
            begin
                // outputs held unchanged until data-ready
                if (mem_data_ready)
                begin
                    s_nxt.mem.request = 1'b0;
                    if (!s_r.mem.write)
                    begin
                        s_nxt.rsp.rdata = info_bus;
                    end
                    s_nxt.rsp.busy = 1'b0;
                    s_nxt.rsp.done = 1'b1;
                    s_nxt.state = cmr_pkg::st_done;
                end
            end
            cmr_pkg::st_done:
            begin
                // one idle cycle so the cpu drops its valid
                s_nxt.state = cmr_pkg::st_idle;
            end
            default:
            begin
                s_nxt.state = cmr_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // cache fill
    // ****************************************
    logic fill;
    logic [cmr_pkg::DATA_W-1:0] fill_data;

    // stores write through and allocate, reads allocate the word returned
    always_comb
    begin
        fill = (s_r.state == cmr_pkg::st_mem) && mem_data_ready;
        fill_data = s_r.mem.write ? s_r.mem.wdata : info_bus;
    end

    // ****************************************
    // tables, cache fill and register block
    // ****************************************
    always_ff @(posedge clock)
    begin
        // page table is not reset and must be loaded before use
        if (pt_we)
        begin
            page_table[pt_page] <= pt_frame;
        end
        if (fill)
        begin
            cache_data[s_r.cidx] <= fill_data;
            cache_tag[s_r.cidx] <= s_r.mem.paddr[cmr_pkg::PADDR_W-1:cmr_pkg::CACHE_IDX_W];
        end
        // register block needs no storage request, one cycle read
        if (reg_we)
        begin
            reg_block[reg_idx] <= reg_wdata;
        end
        reg_rdata <= reg_block[reg_idx];
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            // only valid bits clear, data and tags wait for a fill
            for (int i = 0; i < CACHE_WORDS; i++)
            begin
                cache_vld[i] <= 1'b0;
            end
        end
        else if (fill)
        begin
            cache_vld[s_r.cidx] <= 1'b1;
        end
    end

    assign mem_req = s_r.mem;
    assign cpu_rsp = s_r.rsp;
endmodule

// ===== cmr_pkg.sv
// package for the cpu memory request handshake block
package cmr_pkg;
    localparam int VADDR_W = 16;
    localparam int PADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int PAGE_W = 8;
    localparam int FRAME_W = 10;
    localparam int CACHE_WORDS = 1024;
    localparam int CACHE_IDX_W = 10;
    localparam int PHYS_WORDS = 262144;
    localparam int MOD_SEL_W = 3;
    localparam int REG_COUNT = 128;
    localparam int REG_IDX_W = 7;
    localparam logic [PADDR_W-1:0] LOCAL_LIMIT_RST = 18'h2_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // four access kinds a request carries
    typedef enum logic [1:0]
    {
        instr_fetch_access = 2'b00,
        operand_read_access = 2'b01,
        indirect_addr_read_access = 2'b10,
        operand_store_access = 2'b11
    } cmr_kind_t;

    typedef enum logic [1:0]
    {
        st_idle = 2'b00,
        st_mem = 2'b01,
        st_done = 2'b10
    } cmr_state_t;

    // cpu-side access request
    typedef struct packed
    {
        logic valid;
        cmr_kind_t kind;
        logic [VADDR_W-1:0] vaddr;
        logic [DATA_W-1:0] wdata;
    } cmr_cpu_req_t;

    // storage-side request
    typedef struct packed
    {
        logic request;
        logic write;
        cmr_kind_t kind;
        logic [PADDR_W-1:0] paddr;
        logic local_sel;
        logic [MOD_SEL_W-1:0] module_sel;
        logic multiport_sel;
        logic [DATA_W-1:0] wdata;
    } cmr_mem_req_t;

    // cpu-side answer
    typedef struct packed
    {
        logic busy;
        logic done;
        logic cache_hit;
        logic [DATA_W-1:0] rdata;
    } cmr_cpu_rsp_t;
endpackage

// ===== cmr_checker.sv
// port assertions for the memory request handshake
`timescale 1ns/1ns
module cmr_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // watched ports
    input wire cmr_pkg::cmr_cpu_req_t cpu_req,
    input wire cmr_pkg::cmr_cpu_rsp_t cpu_rsp,
    input wire cmr_pkg::cmr_mem_req_t mem_req,
    input wire logic mem_data_ready,
    input wire logic [cmr_pkg::DATA_W-1:0] info_bus,
    input wire logic [cmr_pkg::PADDR_W-1:0] local_limit
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic rq;
    logic hold;
    assign rq = mem_req.request;
    assign hold = rq && !mem_data_ready;
    a_req_holds: assert property (hold |=> rq)
        else $error("request dropped early");
    a_busy_level: assert property (cpu_rsp.busy == rq)
        else $error("busy differs from request");
    a_req_ends: assert property (rq && mem_data_ready |=> !rq && cpu_rsp.done)
        else $error("transfer not ended");
    a_done_pulse: assert property (cpu_rsp.done |=> !cpu_rsp.done)
        else $error("done longer than one cycle");
    a_req_stable: assert property (hold |=> $stable(mem_req))
        else $error("request changed while waiting");
    a_write_dir: assert property (rq |-> mem_req.write == (mem_req.kind == 2'b11))
        else $error("wrong direction");
    a_read_word: assert property (rq && !mem_req.write && mem_data_ready
        |=> cpu_rsp.rdata == $past(info_bus))
        else $error("read word lost");
    a_req_forms: assert property ($rose(rq) |-> mem_req.kind == $past(cpu_req.kind)
        && mem_req.paddr[7:0] == $past(cpu_req.vaddr[7:0]))
        else $error("request formed wrongly");
    a_module_pick: assert property (rq |-> mem_req.module_sel == mem_req.paddr[17:15])
        else $error("wrong module");
    a_space_split: assert property (rq |-> mem_req.local_sel == (mem_req.paddr < local_limit)
        && mem_req.multiport_sel == !mem_req.local_sel)
        else $error("wrong memory picked");
    cover property (rq && mem_data_ready && mem_req.write);
    cover property (rq && mem_data_ready && !mem_req.write);
    cover property (cpu_rsp.done && cpu_rsp.cache_hit);
endmodule

// ===== cmr_mem_model.sv
// storage model answering handshake requests
`timescale 1ns/1ns
module cmr_mem_model (
    // clock
    input wire logic clock,
    // request side
    input wire cmr_pkg::cmr_mem_req_t mem_req,
    input wire logic [3:0] wait_cycles,
    // answer side
    output logic mem_data_ready = 1'b0,
    output logic [15:0] info_bus = 16'h0000
);
    logic [15:0] mem [int];
    int cnt = 0;
    always @(posedge clock)
    begin
        if (mem_req.request && !mem_data_ready && cnt >= wait_cycles)
        begin
            mem_data_ready <= 1'b1;
            if (mem_req.write)
                mem[mem_req.paddr] = mem_req.wdata;
            else
                info_bus <= mem.exists(mem_req.paddr) ? mem[mem_req.paddr]
                    : mem_req.paddr[15:0];
        end
        else
        begin
            mem_data_ready <= 1'b0;
            info_bus <= ~info_bus;
            cnt <= (mem_req.request && !mem_data_ready) ? cnt + 1 : 0;
        end
    end
endmodule

// ===== tb.sv
// self-checking bench for the memory request handshake
`timescale 1ns/1ns
module tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic pt_we = 1'b0;
    logic reg_we = 1'b0;
    logic mem_data_ready;
    logic [7:0] pt_page = 8'h00;
    logic [9:0] pt_frame = 10'h000;
    logic [6:0] reg_idx = 7'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, info_bus;
    logic [17:0] local_limit = 18'h2_0000;
    logic [3:0] wait_cycles = 4'h0;
    cmr_pkg::cmr_cpu_req_t cpu_req = '0;
    cmr_pkg::cmr_cpu_rsp_t cpu_rsp, got;
    cmr_pkg::cmr_mem_req_t mem_req, mr;
    int fail_count = 0;
    int num_checks = 0;
    int lat;
    cmr_handshake u_cmr_handshake (.clock, .rst, .cpu_req, .cpu_rsp, .pt_we, .pt_page,
        .pt_frame, .local_limit, .reg_we, .reg_idx, .reg_wdata, .reg_rdata, .mem_req,
        .mem_data_ready, .info_bus);
    cmr_mem_model u_cmr_mem_model (.clock, .mem_req, .wait_cycles, .mem_data_ready, .info_bus);
    initial forever #10 clock = ~clock;
    task automatic chk(input logic [63:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("Error %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic pt(input logic [7:0] p, input logic [9:0] f);
        @(posedge clock);
        pt_we <= 1'b1;
        pt_page <= p;
        pt_frame <= f;
        @(posedge clock);
        pt_we <= 1'b0;
    endtask
    // one access, held until done, with latency and storage request captured
    task automatic acc(input logic [1:0] k, input logic [15:0] a, d);
        mr = '0;
        lat = 0;
        @(posedge clock);
        cpu_req <= {1'b1, k, a, d};
        do
        begin
            @(negedge clock);
            lat++;
            if (mem_req.request === 1'b1)
                mr = mem_req;
        end while (cpu_rsp.done !== 1'b1 && lat < 40);
        if (lat >= 40)
        begin
            fail_count++;
            summarize();
        end
        got = cpu_rsp;
        @(posedge clock);
        cpu_req.valid <= 1'b0;
    endtask
    task automatic t_miss_hit;
        wait_cycles <= 4'h3;
        acc(2'b01, 16'h0123, 16'h0000);
        chk(lat, 8'h07);
        chk(mr.paddr, 18'h0_0523);
        chk(mr.local_sel, 1'b1);
        chk(got.rdata, 16'h0523);
        chk({got.busy, got.cache_hit}, 2'b00);
        acc(2'b01, 16'h0123, 16'h0000);
        chk(lat, 8'h02);
        chk({mr.request, got.rdata}, 17'h0_0523);
        chk({got.busy, got.cache_hit}, 2'b01);
    endtask
    task automatic t_kinds;
        wait_cycles <= 4'h0;
        for (int i = 0; i < 3; i++)
        begin
            acc(i[1:0], 16'h0140 + 16'(i), 16'h0000);
            chk(mr.kind, i[1:0]);
            chk({mr.request, mr.write}, 2'b10);
            chk(got.rdata, 16'h0540 + 16'(i));
        end
    endtask
    // store, then a fetch of the same word must hit the written-through line
    task automatic t_store;
        wait_cycles <= 4'h2;
        acc(2'b11, 16'h1234, 16'hbeef);
        chk(lat, 8'h06);
        chk({mr.kind, mr.write, mr.wdata}, 19'h7_beef);
        chk(mr.paddr, 18'h3_ff34);
        chk(mr.module_sel, 3'h7);
        chk({mr.local_sel, mr.multiport_sel}, 2'b01);
        acc(2'b00, 16'h1234, 16'h0000);
        chk(lat, 8'h02);
        chk({mr.request, got.cache_hit, got.rdata}, 18'h1_beef);
    endtask
    task automatic t_regs;
        @(posedge clock);
        reg_we <= 1'b1;
        reg_idx <= 7'h7f;
        reg_wdata <= 16'ha5a5;
        @(posedge clock);
        reg_we <= 1'b0;
        @(negedge clock);
        @(negedge clock);
        chk({mem_req.request, reg_rdata}, 17'h0_a5a5);
    endtask
    // mid-run reset empties the cache, so the earlier hit becomes a miss
    task automatic t_reset;
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        wait_cycles <= 4'h0;
        acc(2'b01, 16'h0123, 16'h0000);
        chk(lat, 8'h04);
        chk({mr.request, got.cache_hit, got.rdata}, 18'h2_0523);
    endtask
    initial
    begin
        repeat (15) @(posedge clock);
        @(negedge clock);
        chk({mem_req, cpu_rsp}, '0);
        @(posedge clock);
        rst <= 1'b0;
        pt(8'h01, 10'h005);
        pt(8'h12, 10'h3ff);
        t_miss_hit();
        t_kinds();
        t_store();
        t_regs();
        t_reset();
        summarize();
    end
endmodule
bind cmr_handshake cmr_checker u_cmr_checker (.clock, .rst, .cpu_req, .cpu_rsp, .mem_req,
    .mem_data_ready, .info_bus, .local_limit);
